// >>> shr_host.sv
/*
 * shr_host: host-side controller for a byte-wide static memory that hides a
 * calendar clock behind a 64-cycle key. Software orders single memory reads and
 * writes or whole clock reads and writes through a small register port.
 * Assumes the socket's data inputs are synchronous to mclk and that the tri-state
 * data wire is resolved outside from dqOut and dqOe.
 */
// What this block does
// - host holds address through write, then gives write recovery time
// - host keeps output enable high during writes
// - unlock is 64 consecutive writes, one key bit on bit 0
// - host opens unlock with a read, resetting comparison pointer
// - unlock writes also hit memory, so use a scratch address
// - host moves clock registers only as whole bytes
// - key bytes c5,3a,a3,5c,c5,3a,a3,5c, each LSB first
`timescale 1ns/1ps
module shr_host import shr_pkg::*; (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   // memory socket
   output shr_pins_t pins,
   input wire logic [DATA_W-1:0] dqIn,
   output logic abortN,
   input wire logic powerFail
);

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_RAM = 3'b001,
      S_OPEN = 3'b010,
      S_KEY = 3'b011,
      S_XFER = 3'b100
   } shr_seq_t;

   shr_seq_t state_r;
   shr_op_t op_r;
   logic [ADDR_W-1:0] addr_r;
   logic [DATA_W-1:0] wdata_r;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] clkBuf_r [CLK_REGS];
   logic [5:0] bitCnt_r;
   logic issued_r;
   logic done_r;
   logic aborted_r;
   logic stop_r;
   logic [3:0] abortCnt_r;

   logic engIdle;
   logic engDone;
   logic [DATA_W-1:0] engRd;
   logic reqValid;
   shr_req_t req;
   logic goWr;
   logic abortWr;
   logic busy;
   logic lastBit;
   logic capture;

   assign busy = (state_r != S_IDLE);
   assign goWr = regWr && (regAddr == REG_CTRL) && regWdata[CTRL_GO];
   assign abortWr = regWr && (regAddr == REG_CTRL) && regWdata[CTRL_ABORT];
   assign lastBit = (bitCnt_r == LAST_BIT);
   // clock read: bit n lands in image byte n/8, bit n%8
   assign capture = engDone && (state_r == S_XFER) && (op_r == OP_CLK_RD);

   // one cycle at a time; a stop request ends the sequence between cycles
   assign reqValid = busy && !issued_r && engIdle && !stop_r;

   always_comb begin
      req = '{write: 1'b0, addr: addr_r, data: BYTE_RST};
      unique case (state_r)
         S_RAM: begin
            // single memory access outside any clock sequence
            req.write = (op_r == OP_RAM_WR);
            req.data = wdata_r;
         end
         S_OPEN: begin
            // opening read at the scratch address resets the pointer
            req.write = 1'b0;
         end
         S_KEY: begin
            // key bit n on data bit 0, every cycle a write
            // the scratch byte gets overwritten by these
            req.write = 1'b1;
            req.data = {7'h00, UNLOCK_KEY[bitCnt_r]};
         end
         S_XFER: begin
            // clock bits in order, register 0 bit 0 first
            req.write = (op_r == OP_CLK_WR);
            req.data = {7'h00, clkBuf_r[bitCnt_r[5:3]][bitCnt_r[2:0]]};
         end
         default: begin
            req.write = 1'b0;
         end
      endcase
   end

   shr_cycle_engine engine (
      .mclk(mclk),
      .resetn(resetn),
      .req(req),
      .reqValid(reqValid),
      .idle(engIdle),
      .done(engDone),
      .rdByte(engRd),
      .pins(pins),
      .dqIn(dqIn)
   );

   // sequencer
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_r <= S_IDLE;
         bitCnt_r <= 6'h00;
         issued_r <= 1'b0;
      end else if (state_r == S_IDLE) begin
         issued_r <= 1'b0;
         bitCnt_r <= 6'h00;
         // the op comes from the order word itself, in the same cycle as go
         // no new order while the supply is flagged bad
         if (goWr && !powerFail) begin
            if (regWdata[CTRL_OP_LO+1]) begin
               state_r <= S_OPEN;
            end else begin
               state_r <= S_RAM;
            end
         end
      end else if (reqValid) begin
         issued_r <= 1'b1;
      end else if (stop_r && engIdle && !issued_r) begin
         state_r <= S_IDLE;
      end else if (engDone) begin
         issued_r <= 1'b0;
         unique case (state_r)
            S_RAM: state_r <= S_IDLE;
            S_OPEN: begin
               bitCnt_r <= 6'h00;
               state_r <= S_KEY;
            end
            S_KEY: begin
               // no read may slip into the 64 key writes
               bitCnt_r <= bitCnt_r + 6'h01;
               if (lastBit) begin
                  state_r <= S_XFER;
               end
            end
            S_XFER: begin
               // exactly 64 clock cycles, then back to plain memory
               bitCnt_r <= bitCnt_r + 6'h01;
               if (lastBit) begin
                  state_r <= S_IDLE;
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // stop request: abort order or supply loss while busy
   // stops fall between memory cycles, never inside a strobe
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         stop_r <= 1'b0;
      end else if (!busy) begin
         stop_r <= 1'b0;
      end else if (abortWr || powerFail) begin
         stop_r <= 1'b1;
      end
   end

   // abort pin low for the least reset width
   // a second abort order restarts the count, so the pulse never shortens
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         abortCnt_r <= 4'h0;
         abortN <= 1'b1;
      end else if (abortWr) begin
         abortCnt_r <= RST_CYC - 4'h1;
         abortN <= 1'b0;
      end else if (abortCnt_r != 4'h0) begin
         abortCnt_r <= abortCnt_r - 4'h1;
      end else begin
         abortN <= 1'b1;
      end
   end

   // status flags; a finishing sequence beats the clear from a new order
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         done_r <= 1'b0;
         aborted_r <= 1'b0;
      end else if (busy && stop_r && engIdle && !issued_r) begin
         done_r <= 1'b1;
         aborted_r <= 1'b1;
      end else if (engDone && (state_r == S_RAM ||
                   (state_r == S_XFER && lastBit))) begin
         // a stop that lands on the final cycle still reports as aborted
         done_r <= 1'b1;
         aborted_r <= stop_r;
      end else if (goWr && !busy && !powerFail) begin
         // a refused order leaves the last result readable
         done_r <= 1'b0;
         aborted_r <= 1'b0;
      end
   end

   // order registers, frozen while a sequence runs
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         op_r <= OP_RAM_RD;
         addr_r <= ADDR_RST;
         wdata_r <= BYTE_RST;
      end else if (regWr && !busy) begin
         // a refused order must not change the op shown in CTRL
         if (regAddr == REG_CTRL && regWdata[CTRL_GO] && !powerFail) begin
            op_r <= shr_op_t'(regWdata[CTRL_OP_LO +: 2]);
         end
         // any of the 32768 byte addresses
         if (regAddr == REG_ADDR) begin
            addr_r <= regWdata[ADDR_W-1:0];
         end
         if (regAddr == REG_WDATA) begin
            wdata_r <= regWdata[DATA_W-1:0];
         end
      end
   end

   // byte from the last memory read
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdata_r <= BYTE_RST;
      end else if (engDone && state_r == S_RAM && op_r == OP_RAM_RD) begin
         rdata_r <= engRd;
      end
   end

   // clock image: software fills it whole bytes at a time
   for (genvar g = 0; g < CLK_REGS; g++) begin : g_clkBuf
      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            clkBuf_r[g] <= BYTE_RST;
         end else if (regWr && !busy && regAddr == REG_CLKBUF + 8'(4 * g)) begin
            clkBuf_r[g] <= regWdata[DATA_W-1:0];
         end else if (capture && bitCnt_r[5:3] == 3'(g)) begin
            clkBuf_r[g][bitCnt_r[2:0]] <= engRd[0];
         end
      end
   end

   // register read port, data in the cycle after the strobe
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         regRdata <= 32'h0000_0000;
      end else if (regRd) begin
         // unmapped addresses read as zero
         regRdata <= 32'h0000_0000;
         if (regAddr == REG_CTRL) begin
            regRdata[CTRL_OP_LO +: 2] <= op_r;
         end else if (regAddr == REG_STATUS) begin
            regRdata[STAT_BUSY] <= busy;
            regRdata[STAT_DONE] <= done_r;
            regRdata[STAT_PFAIL] <= powerFail;
            regRdata[STAT_ABORTED] <= aborted_r;
         end else if (regAddr == REG_ADDR) begin
            regRdata[ADDR_W-1:0] <= addr_r;
         end else if (regAddr == REG_WDATA) begin
            regRdata[DATA_W-1:0] <= wdata_r;
         end else if (regAddr == REG_RDATA) begin
            regRdata[DATA_W-1:0] <= rdata_r;
         end else if (regAddr >= REG_CLKBUF && regAddr < REG_CLKBUF + 8'h20 &&
                      regAddr[1:0] == 2'b00) begin
            regRdata[DATA_W-1:0] <= clkBuf_r[regAddr[4:2]];
         end
      end
   end

endmodule // shr_host

// >>> shr_pkg.sv
/*
 * shr_pkg: constants, timing counts, register map and carrier types for the
 * host-side controller of a byte-wide static memory with a hidden calendar clock.
 * Assumes a single 40 MHz clock (25 ns) in every module that imports it.
 */
package shr_pkg;

   // clock period and printed timing figures, slowest speed grade
   localparam int CLK_NS = 25;
   localparam int T_WP_NS = 150;
   localparam int T_ACC_NS = 200;
   localparam int T_WR_NS = 20;
   localparam int T_OD_NS = 100;
   localparam int T_RST_NS = 200;

   // all are least times, so they round up to whole cycles
   localparam logic [3:0] WP_CYC = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] WR_CYC = 4'((T_WR_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] OD_CYC = 4'((T_OD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] RST_CYC = 4'((T_RST_NS + CLK_NS - 1) / CLK_NS);

   // memory geometry and hidden clock layout
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int CLK_REGS = 8;
   localparam logic [5:0] LAST_BIT = 6'h3f;
   // key bytes c5,3a,a3,5c twice; bit n of this word is sent in cycle n
   localparam logic [63:0] UNLOCK_KEY = 64'h5ca33ac55ca33ac5;

   // register map of the controller, byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_ADDR = 8'h08;
   localparam logic [7:0] REG_WDATA = 8'h0c;
   localparam logic [7:0] REG_RDATA = 8'h10;
   localparam logic [7:0] REG_CLKBUF = 8'h20;

   // control fields
   localparam int CTRL_GO = 0;
   localparam int CTRL_OP_LO = 1;
   localparam int CTRL_ABORT = 3;
   // status fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_PFAIL = 2;
   localparam int STAT_ABORTED = 3;

   // reset values
   localparam logic [14:0] ADDR_RST = 15'h0000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [1:0] OP_RST = 2'h0;

   typedef enum logic [1:0] {
      OP_RAM_RD = 2'b00,
      OP_RAM_WR = 2'b01,
      OP_CLK_RD = 2'b10,
      OP_CLK_WR = 2'b11
   } shr_op_t;

   // one memory cycle asked of the cycle engine
   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } shr_req_t;

   // every socket pin the controller drives except abortN
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic ceN;
      logic weN;
      logic oeN;
      logic [DATA_W-1:0] dqOut;
      logic dqOe;
   } shr_pins_t;

endpackage

// >>> shr_cycle_engine.sv
/*
 * shr_cycle_engine: runs one asynchronous static memory read or write cycle on
 * the socket pins, with setup, strobe width, recovery and turnaround counts.
 * Assumes requests arrive only while idle is high and data inputs are synchronous.
 */
`timescale 1ns/1ps
module shr_cycle_engine import shr_pkg::*; (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // request and answer
   input wire shr_req_t req,
   input wire logic reqValid,
   output logic idle,
   output logic done,
   output logic [DATA_W-1:0] rdByte,
   // socket pins
   output shr_pins_t pins,
   input wire logic [DATA_W-1:0] dqIn
);

   typedef enum logic [1:0] {
      E_IDLE = 2'b00,
      E_SETUP = 2'b01,
      E_STROBE = 2'b10,
      E_RECOV = 2'b11
   } shr_eng_t;

   shr_eng_t state_r;
   logic isWr_r;
   logic [3:0] cnt_r;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_r <= E_IDLE;
         isWr_r <= 1'b0;
         cnt_r <= 4'h0;
         idle <= 1'b1;
         done <= 1'b0;
         rdByte <= BYTE_RST;
         pins <= '{addr: ADDR_RST, ceN: 1'b1, weN: 1'b1, oeN: 1'b1,
                   dqOut: BYTE_RST, dqOe: 1'b0};
      end else begin
         done <= 1'b0;
         unique case (state_r)
            E_IDLE: begin
               if (reqValid) begin
                  // address settles a cycle before any strobe
                  pins.addr <= req.addr;
                  pins.dqOut <= req.data;
                  pins.dqOe <= req.write;
                  isWr_r <= req.write;
                  idle <= 1'b0;
                  state_r <= E_SETUP;
               end
            end
            E_SETUP: begin
               pins.ceN <= 1'b0;
               pins.weN <= ~isWr_r;
               // output enable stays high through writes
               pins.oeN <= isWr_r;
               cnt_r <= isWr_r ? WP_CYC - 4'h1 : ACC_CYC - 4'h1;
               state_r <= E_STROBE;
            end
            E_STROBE: begin
               if (cnt_r == 4'h0) begin
                  pins.ceN <= 1'b1;
                  pins.weN <= 1'b1;
                  pins.oeN <= 1'b1;
                  if (!isWr_r) begin
                     rdByte <= dqIn;
                  end
                  // write strobe high for recovery, data still held
                  cnt_r <= isWr_r ? WR_CYC - 4'h1 : OD_CYC - 4'h1;
                  state_r <= E_RECOV;
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
            E_RECOV: begin
               if (cnt_r == 4'h0) begin
                  pins.dqOe <= 1'b0;
                  done <= 1'b1;
                  idle <= 1'b1;
                  state_r <= E_IDLE;
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
         endcase
      end
   end

endmodule // shr_cycle_engine

// >>> shr_host_properties.sv
/* shr_host_properties: socket timing checks on the ports of shr_host.
   assumes one clock domain; bound to every shr_host instance below. */
`timescale 1ns/1ps
module shr_host_properties import shr_pkg::*; (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [31:0] regRdata,
   // memory socket
   input wire shr_pins_t pins,
   input wire logic [DATA_W-1:0] dqIn,
   input wire logic abortN,
   input wire logic powerFail
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence s_wr_pulse;
      (!pins.weN && !pins.ceN && pins.oeN) [*6] ##1 (pins.weN && pins.ceN);
   endsequence
   sequence s_rd_pulse;
      (!pins.oeN && !pins.ceN && pins.weN) [*8] ##1 (pins.oeN && pins.ceN);
   endsequence
   // nine cycles covers any memory cycle already under way
   sequence s_pfail_held;
      powerFail [*8] ##1 (powerFail && pins.ceN);
   endsequence

   a_write_pulse: assert property ($fell(pins.weN) |-> s_wr_pulse)
      else $error("write strobe pulse has the wrong shape");
   a_read_pulse: assert property ($fell(pins.oeN) |-> s_rd_pulse)
      else $error("read strobe pulse has the wrong shape");
   a_addr_steady: assert property (!pins.ceN && !$past(pins.ceN) |->
      $stable(pins.addr))
      else $error("address moved while selected");
   a_write_recovery: assert property ($rose(pins.weN) |-> pins.ceN [*2])
      else $error("no recovery after write");
   a_oe_quiet: assert property (!pins.weN || pins.dqOe |-> pins.oeN)
      else $error("output enable low while writing");
   a_data_drive: assert property (!pins.weN |-> pins.dqOe)
      else $error("write strobe without driven data");
   a_data_hold: assert property ($rose(pins.weN) |->
      pins.dqOe && $stable(pins.dqOut))
      else $error("write data not held past strobe");
   a_select_strobed: assert property ($fell(pins.ceN) |-> !pins.weN || !pins.oeN)
      else $error("select without a strobe");
   a_abort_width: assert property ($fell(abortN) |-> !abortN [*8] ##1 abortN)
      else $error("abort pulse is not eight cycles");
   a_pfail_halt: assert property (s_pfail_held |=> pins.ceN)
      else $error("new cycle started in power fail");
endmodule // shr_host_properties

bind shr_host shr_host_properties u_shr_host_properties (
   .mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
   .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pins(pins),
   .dqIn(dqIn), .abortN(abortN), .powerFail(powerFail)
);

// >>> shr_device_model.sv
/* shr_device_model: behavioural byte memory with a clock hidden behind a key.
   assumes socket pins change just after mclk edges, sampled on the next. */
`timescale 1ns/1ps
module shr_device_model import shr_pkg::*; (
   // clock
   input wire logic mclk,
   // socket
   input wire shr_pins_t pins,
   input wire logic abortN,
   input wire logic powerFail,
   output logic [DATA_W-1:0] dqIn
);
   localparam int DAY_REG = 4;
   localparam logic [63:0] KEY = {8'h5c, 8'ha3, 8'h3a, 8'hc5,
      8'h5c, 8'ha3, 8'h3a, 8'hc5};
   logic [7:0] mem [0:32767];
   // byte n is register n, kept as written
   // oscillator kept stopped, so nothing counts
   logic [63:0] clkBits;
   logic [63:0] shadow;
   logic [14:0] wAddr;
   logic [7:0] wData;
   logic [6:0] xfer;
   logic [5:0] ptr;
   logic wSel, rSel, open, lost;

   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
      clkBits = 64'h0;
      clkBits[8*DAY_REG+4] = 1'b1;
      clkBits[8*DAY_REG+5] = 1'b1;
      {shadow, wAddr, wData, xfer, ptr, wSel, rSel, open} = '0;
      lost = 1'b1;
      dqIn = 8'h00;
   end

   always @(posedge mclk) begin
      // deselected cycles still toggle dqIn and commit a write latched in the cycle before
      wSel <= !pins.ceN && !pins.weN && !powerFail;
      rSel <= !pins.ceN && !pins.oeN && pins.weN && !powerFail;
      if (!pins.ceN && !pins.weN) begin
         wAddr <= pins.addr;
         wData <= pins.dqOut;
      end
      // released lines wander, never hold the last value
      if (powerFail || pins.ceN || pins.oeN || !pins.weN) begin
         dqIn <= ~dqIn;
      end else if (open) begin
         dqIn <= {~dqIn[7:1], clkBits[xfer[5:0]]};
      end else begin
         dqIn <= mem[pins.addr];
      end
      if (!rSel && !pins.ceN && !pins.oeN && pins.weN && !open && !powerFail) begin
         ptr <= 6'h0;
         lost <= 1'b0;
      end
      if (wSel && pins.weN) begin
         if (open) begin
            shadow[xfer[5:0]] = wData[0];
         end else begin
            mem[wAddr] <= wData;
            if (!lost && wData[0] === KEY[ptr]) begin
               ptr <= ptr + 6'h1;
               if (ptr == 6'h3f) begin
                  open <= 1'b1;
                  lost <= 1'b1;
                  xfer <= 7'h0;
                  shadow = clkBits;
               end
            end else begin
               lost <= 1'b1;
            end
         end
      end
      if (open && ((wSel && pins.weN) || (rSel && pins.oeN))) begin
         xfer <= xfer + 7'h1;
         if (xfer == 7'h3f) begin
            open <= 1'b0;
            clkBits <= shadow;
         end
      end
      if (!abortN && !clkBits[8*DAY_REG+4] && open) begin
         open <= 1'b0; // registers untouched
      end
   end
endmodule // shr_device_model

// >>> shr_host_bench.sv
/* shr_host_bench: self-checking bench for shr_host driving a device model.
   assumes shr_host_properties is compiled and bound beforehand. */
`timescale 1ns/1ps
module shr_host_bench import shr_pkg::*; ();
   logic mclk = 1'b0, resetn = 1'b0, regWr = 1'b0, regRd = 1'b0, powerFail = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0, regRdata, got;
   logic [DATA_W-1:0] dqIn;
   logic abortN, rdSeen = 1'b0;
   shr_pins_t pins;
   int errors = 0, check_count = 0;
   logic [63:0] noteQ [$];
   logic [63:0] bytes;
   logic [14:0] a;
   logic [7:0] d;

   always #12.5 mclk = ~mclk;

   shr_host u_shr_host (
      .mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pins(pins),
      .dqIn(dqIn), .abortN(abortN), .powerFail(powerFail)
   );
   shr_device_model u_shr_device_model (
      .mclk(mclk), .pins(pins), .abortN(abortN), .powerFail(powerFail), .dqIn(dqIn)
   );

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic fail(input string m);
      errors++;
      $display("unexpected at %0t: %s", $time, m);
   endtask
   task automatic same(input logic [63:0] g, input logic [63:0] e);
      check_count++;
      if (g !== e) fail("model state differs");
   endtask
   // a read notes {mask, value}; a zero mask is a poll
   task automatic access(input logic w, input logic [7:0] ad, input logic [31:0] v,
                         input logic [31:0] m);
      @(posedge mclk);
      regAddr <= ad;
      regWdata <= v;
      if (w) regWr <= 1'b1;
      else regRd <= 1'b1;
      if (!w) noteQ.push_back({m, v});
      @(posedge mclk);
      regWr <= 1'b0;
      regRd <= 1'b0;
      #1 got = regRdata;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] v);
      access(1'b1, ad, v, 32'h0);
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] v, input logic [31:0] m);
      access(1'b0, ad, v, m);
   endtask
   task automatic waitIdle();
      int n;
      n = 0;
      do begin
         rd(REG_STATUS, 32'h0, 32'h0);
         n++;
      end while (got[STAT_BUSY] !== 1'b0 && n < 1200);
      if (n >= 1200) begin
         fail("busy never cleared");
         tally_and_finish();
      end
   endtask
   task automatic run(input logic [1:0] op);
      wr(REG_CTRL, {29'h0, op, 1'b1});
      waitIdle();
   endtask

   // read data stand from the cycle after the strobe until the next read strobe
   always @(posedge mclk) begin
      logic [63:0] n;
      if (rdSeen) begin
         n = noteQ.pop_front();
         if (n[63:32] != 32'h0) begin
            check_count++;
            if ((regRdata & n[63:32]) !== (n[31:0] & n[63:32])) fail("read data differs");
         end
      end
      rdSeen <= regRd;
   end

   initial begin
      void'($urandom(31));
      repeat (6) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      #1 same(64'({pins.ceN, pins.weN, pins.oeN, pins.dqOe, abortN}), 64'h1d);
      rd(REG_STATUS, 32'h0, 32'hf);
      wr(8'h44, 32'hffff_ffff);
      rd(8'h44, 32'h0, 32'hffff_ffff);
      for (int i = 0; i < 3; i++) begin
         a = 15'($urandom);
         d = 8'($urandom);
         wr(REG_ADDR, {17'h0, a});
         wr(REG_WDATA, {24'h0, d});
         run(OP_RAM_WR);
         same(64'(u_shr_device_model.mem[a]), 64'(d));
         run(OP_RAM_RD);
         rd(REG_RDATA, {24'h0, d}, 32'hff);
      end
      rd(REG_CTRL, 32'h0, 32'h6);
      bytes = {$urandom, $urandom};
      // oscillator stays stopped so the image reads back unchanged
      bytes[8*4+5] = 1'b1;
      for (int i = 0; i < 8; i++) begin
         wr(REG_CLKBUF + 8'(4 * i), {24'h0, bytes[8*i +: 8]});
      end
      run(OP_CLK_WR);
      same(u_shr_device_model.clkBits, bytes);
      same(64'(u_shr_device_model.mem[a]), 64'h0);
      for (int i = 0; i < 8; i++) begin
         wr(REG_CLKBUF + 8'(4 * i), 32'h0);
      end
      run(OP_CLK_RD);
      for (int i = 0; i < 8; i++) begin
         rd(REG_CLKBUF + 8'(4 * i), {24'h0, bytes[8*i +: 8]}, 32'hff);
      end
      run(OP_RAM_RD);
      rd(REG_RDATA, 32'h0, 32'hff);
      wr(REG_CTRL, {29'h0, OP_CLK_RD, 1'b1});
      rd(REG_STATUS, 32'h1, 32'h1);
      wr(REG_WDATA, 32'h5a);
      wr(REG_CTRL, 32'h8);
      same(64'(abortN), 64'h0);
      waitIdle();
      rd(REG_STATUS, 32'ha, 32'hb);
      rd(REG_WDATA, {24'h0, d}, 32'hff);
      // abort landing inside a single memory read
      wr(REG_CTRL, {29'h0, OP_RAM_RD, 1'b1});
      wr(REG_CTRL, 32'h8);
      waitIdle();
      rd(REG_STATUS, 32'ha, 32'hb);
      @(posedge mclk) powerFail <= 1'b1;
      wr(REG_CTRL, 32'h3);
      rd(REG_STATUS, 32'he, 32'hf);
      rd(REG_CTRL, 32'h0, 32'h6);
      @(posedge mclk) powerFail <= 1'b0;
      wr(REG_CTRL, {29'h0, OP_CLK_RD, 1'b1});
      @(posedge mclk) powerFail <= 1'b1;
      waitIdle();
      rd(REG_STATUS, 32'he, 32'hf);
      @(posedge mclk) powerFail <= 1'b0;
      repeat (2) @(posedge mclk);
      tally_and_finish();
   end
endmodule // shr_host_bench
